// ### spi_slave_process_port.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - With three-byte addressing, third interrupt byte goes out during third address byte.
// - Master-in line is undefined during write data; we drive zero.
// - Read data bytes go out from start address, incrementing per byte.
// - Only the first read byte waits; later bytes are prefetched.
// - All-ones final read byte stops further prefetch.
// - A low bit during a read byte forces another prefetch and byte.
// - Clock count not a multiple of eight flags an access error.
// - Data-byte clock during first-byte fetch flags a read error.
// - Missing all-ones termination or bytes after termination flag read errors.
// - Errored access still writes RAM, blocks register writes and side effects.
// - Each erroneous access increments the error counter.
// - Status bit driven from select to first clock: high good, low bad.
// - Status bit absent in modes 0/2 with normal data-out sampling.
// - Cause of latest error is kept in an error code output.
// - Four-byte write address phase with extension then write is accepted.
// - Any number of extension bytes; last one's address wins.
// - Busy indication starts one clock period after the last command bit.
// - Interrupt output delayed by fixed interval after application event.
// - Three-bit commands: nop, read, read-wait, write, extension; rest reserved.
// - Two-byte addresses bits 12..0; third byte carries bits 15..13.
// - MSB first, low byte first, address increments after each byte.
// - First two interrupt bytes go out during first two address bytes.
module spi_slave_process_port
    import spi_port_pkg::*;
#(
    parameter int FETCH_DELAY = FETCH_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spiSel_b,
    input wire logic spiClk,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOutEn,
    output logic spiIrq_b,
    input wire logic clockPhase,
    input wire logic clockPolarity,
    input wire logic lateSample,
    input wire logic busyOutEnable,
    input wire logic [23:0] applicationEvent,
    input wire logic [7:0] readData,
    output logic [15:0] memAddr,
    output logic memRead,
    output logic memWrite,
    output logic [7:0] memWriteData,
    output logic regWriteAllowed,
    output logic sideEffectStrobe,
    input wire logic memWriteReady,
    output logic [7:0] errorCount,
    output logic [3:0] errorCode,
    output logic accessGood
);
    initial
    begin
        if (FETCH_DELAY < 1 || FETCH_DELAY > 15)
            $error("FETCH_DELAY out of range");
    end
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection
    logic [2:0] syncA, syncB;
    logic selPrev, clkPrev;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            syncA <= 3'h7;
            syncB <= 3'h7;
            selPrev <= 1'b0;
            clkPrev <= 1'b0;
        end
        else
        begin
            syncA <= {spiSel_b, spiClk, serialDataIn};
            syncB <= syncA;
            selPrev <= !syncB[2];
            clkPrev <= syncB[1];
        end
    end
    logic selected, sclk, mosi, leading, trailing, sampleEdge, shiftEdge, selStart, selEnd;
    always_comb
    begin
        selected = !syncB[2];
        sclk = syncB[1] ^ clockPolarity;
        mosi = syncB[0];
        leading = selected && sclk && !(clkPrev ^ clockPolarity);
        trailing = selected && !sclk && (clkPrev ^ clockPolarity);
        sampleEdge = clockPhase ? trailing : leading;
        shiftEdge = clockPhase ? leading : trailing;
        selStart = selected && !selPrev;
        selEnd = !selected && selPrev;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Interrupt delay line
    logic [23:0] irqLatch;
    logic [IRQ_DELAY_CYCLES-1:0] irqPipe;
    logic next_irq;
    always_comb
    begin
        next_irq = !irqPipe[IRQ_DELAY_CYCLES-1];
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irqPipe <= '0;
            spiIrq_b <= 1'b1;
            irqLatch <= '0;
        end
        else
        begin
            irqPipe <= {irqPipe[IRQ_DELAY_CYCLES-2:0], |applicationEvent};
            spiIrq_b <= next_irq;
            if (selStart)
                irqLatch <= applicationEvent;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Write path FIFO: address and data
    logic fifoInValid, fifoInReady, fifoOutValid;
    logic [23:0] fifoInData, fifoOutData;
    word_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) writeQueue (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(memWriteReady),
        .outData(fifoOutData)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Transfer state
    phase_t phase, next_phase;
    logic [2:0] bitCnt, next_bitCnt;
    logic [1:0] addrByte, next_addrByte;
    logic [7:0] rxShift, next_rxShift, txShift, next_txShift, prefetch, next_prefetch;
    logic [15:0] addr, next_addr;
    logic [3:0] fetchCnt, next_fetchCnt;
    logic fetching, next_fetching, moreLow, next_moreLow, terminated, next_terminated;
    logic waitByte, next_waitByte, sawClock, next_sawClock, busyOn, next_busyOn;
    logic errFlag, next_errFlag;
    logic [3:0] errCause, next_errCause;
    logic [7:0] byteIn;
    logic [2:0] cmd;
    always_comb
    begin
        next_phase = phase;
        next_bitCnt = bitCnt;
        next_addrByte = addrByte;
        next_rxShift = rxShift;
        next_txShift = txShift;
        next_prefetch = prefetch;
        next_addr = addr;
        next_fetchCnt = fetchCnt;
        next_fetching = fetching;
        next_moreLow = moreLow;
        next_terminated = terminated;
        next_waitByte = waitByte;
        next_sawClock = sawClock;
        next_busyOn = busyOn;
        next_errFlag = errFlag;
        next_errCause = errCause;
        fifoInValid = 1'b0;
        fifoInData = {addr, rxShift};
        byteIn = {rxShift[6:0], mosi};
        // Extension bytes carry their command in the middle, ahead of two reserved bits
        cmd = (addrByte == 2'h2) ? byteIn[4:2] : byteIn[2:0];
        if (fetching)
        begin
            if (fetchCnt == 4'h0)
            begin
                next_fetching = 1'b0;
                next_prefetch = readData;
                next_busyOn = 1'b0;
            end
            else
                next_fetchCnt = fetchCnt - 4'h1;
        end
        if (selStart)
        begin
            next_phase = ST_ADDR;
            next_bitCnt = 3'h0;
            next_addrByte = 2'h0;
            next_addr = 16'h0000;
            next_errFlag = 1'b0;
            next_terminated = 1'b0;
            next_sawClock = 1'b0;
            next_busyOn = 1'b0;
            next_txShift = applicationEvent[7:0];
        end
        else if (selEnd)
        begin
            next_phase = ST_IDLE;
            next_busyOn = 1'b0;
            if (bitCnt != 3'h0)
            begin
                next_errFlag = 1'b1;
                next_errCause = ERR_PARTIAL_BYTE;
            end
            else if (phase == ST_READ && !terminated)
            begin
                next_errFlag = 1'b1;
                next_errCause = ERR_NO_TERMINATION;
            end
        end
        else if (sampleEdge)
        begin
            next_sawClock = 1'b1;
            next_rxShift = byteIn;
            next_bitCnt = bitCnt + 3'h1;
            // Clocking the wait byte during the fetch is legal; only data clocks are not
            if (phase == ST_READ && fetching && !moreLow)
            begin
                next_errFlag = 1'b1;
                next_errCause = ERR_CLOCK_WHILE_BUSY;
            end
            if (phase == ST_READ && !mosi)
            begin
                next_moreLow = 1'b1;
                // First low bit starts the prefetch, leaving most of a byte for it
                if (!moreLow)
                begin
                    next_fetching = 1'b1;
                    next_fetchCnt = 4'(FETCH_DELAY);
                    next_addr = addr + 16'h0001;
                end
            end
            if (bitCnt == 3'h7)
            begin
                case (phase)
                    ST_ADDR:
                    begin
                        next_addrByte = addrByte + 2'h1;
                        if (addrByte == 2'h0)
                        begin
                            next_addr[12:5] = byteIn;
                            next_txShift = irqLatch[15:8];
                        end
                        else if (addrByte == 2'h1)
                            next_addr[4:0] = byteIn[7:3];
                        else
                            next_addr[15:13] = byteIn[7:5];
                        if (addrByte != 2'h0)
                        begin
                            if (cmd == CMD_EXTEND)
                            begin
                                next_txShift = irqLatch[23:16];
                                next_addrByte = 2'h2;
                            end
                            else if (cmd == CMD_READ || cmd == CMD_READ_WAIT)
                            begin
                                next_phase = ST_READ;
                                next_waitByte = cmd == CMD_READ_WAIT;
                                if (cmd == CMD_READ_WAIT)
                                    next_phase = ST_WAIT;
                                next_fetching = 1'b1;
                                next_fetchCnt = 4'(FETCH_DELAY);
                                next_busyOn = busyOutEnable;
                                next_moreLow = 1'b0;
                            end
                            else if (cmd == CMD_WRITE)
                                next_phase = ST_WRITE;
                            else
                                next_phase = ST_DONE;
                        end
                    end
                    ST_WAIT:
                        next_phase = ST_READ;
                    ST_READ:
                    begin
                        next_moreLow = 1'b0;
                        if (byteIn == ALL_ONES)
                        begin
                            next_terminated = 1'b1;
                            next_phase = ST_DONE;
                        end
                    end
                    ST_WRITE:
                    begin
                        fifoInValid = 1'b1;
                        fifoInData = {addr, byteIn};
                        next_addr = addr + 16'h0001;
                    end
                    ST_DONE:
                        if (terminated)
                        begin
                            next_errFlag = 1'b1;
                            next_errCause = ERR_AFTER_TERMINATION;
                        end
                    default:
                        next_phase = ST_IDLE;
                endcase
            end
        end
        else if (shiftEdge)
        begin
            next_sawClock = 1'b1;
            if (bitCnt == 3'h0 && phase == ST_READ)
                next_txShift = prefetch;
            else if (bitCnt == 3'h0 && phase == ST_WRITE)
                next_txShift = 8'h00;
            else if (bitCnt != 3'h0)
                next_txShift = {txShift[6:0], 1'b0};
            // At a byte start the freshly loaded bit 7 must stay on the line
        end
        if (phase == ST_READ && !fetching && bitCnt == 3'h0 && !sampleEdge && next_fetching == 1'b0
            && fetchCnt == 4'h0 && moreLow)
            next_moreLow = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Registers and outputs
    logic statusWindow, next_doOut, next_doEn;
    always_comb
    begin
        statusWindow = selected && !sawClock && (clockPhase || lateSample);
        next_doEn = selected;
        if (statusWindow)
            next_doOut = accessGood;
        else if (busyOn)
            next_doOut = fetching;
        else
            next_doOut = txShift[7];
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase <= ST_IDLE;
            bitCnt <= 3'h0;
            addrByte <= 2'h0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
            prefetch <= 8'h00;
            addr <= 16'h0000;
            fetchCnt <= 4'h0;
            fetching <= 1'b0;
            moreLow <= 1'b0;
            terminated <= 1'b0;
            waitByte <= 1'b0;
            sawClock <= 1'b0;
            busyOn <= 1'b0;
            errFlag <= 1'b0;
            errCause <= ERR_NONE;
            serialDataOut <= 1'b1;
            serialDataOutEn <= 1'b0;
            memAddr <= 16'h0000;
            memRead <= 1'b0;
            memWrite <= 1'b0;
            memWriteData <= 8'h00;
            regWriteAllowed <= 1'b0;
            sideEffectStrobe <= 1'b0;
            errorCount <= ERR_COUNT_RESET;
            errorCode <= ERR_NONE;
            accessGood <= 1'b1;
        end
        else
        begin
            phase <= next_phase;
            bitCnt <= next_bitCnt;
            addrByte <= next_addrByte;
            rxShift <= next_rxShift;
            txShift <= next_txShift;
            prefetch <= next_prefetch;
            addr <= next_addr;
            fetchCnt <= next_fetchCnt;
            fetching <= next_fetching;
            moreLow <= next_moreLow;
            terminated <= next_terminated;
            waitByte <= next_waitByte;
            sawClock <= next_sawClock;
            busyOn <= next_busyOn;
            errFlag <= next_errFlag;
            errCause <= next_errCause;
            serialDataOut <= next_doOut;
            serialDataOutEn <= next_doEn;
            memAddr <= next_fetching ? next_addr : fifoOutData[23:8];
            memRead <= next_fetching && !fetching;
            memWrite <= fifoOutValid && memWriteReady;
            memWriteData <= fifoOutData[7:0];
            regWriteAllowed <= !next_errFlag;
            sideEffectStrobe <= selEnd && !next_errFlag;
            if (selEnd && next_errFlag)
            begin
                errorCount <= errorCount + 8'h01;
                errorCode <= next_errCause;
            end
            if (selEnd)
                accessGood <= !next_errFlag;
        end
    end
endmodule
`default_nettype wire

// ### spi_port_pkg.sv
package spi_port_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int READ_TIME_NS = 240;
    localparam int IRQ_DELAY_NS = 160;
    localparam int IRQ_DELAY_CYCLES = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FETCH_CYCLES = 4;
    localparam int BITS_PER_BYTE = 8;
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_READ_WAIT = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_EXTEND = 3'h6;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_PARTIAL_BYTE = 4'h1;
    localparam logic [3:0] ERR_CLOCK_WHILE_BUSY = 4'h2;
    localparam logic [3:0] ERR_NO_TERMINATION = 4'h3;
    localparam logic [3:0] ERR_AFTER_TERMINATION = 4'h4;
    localparam logic [7:0] ERR_COUNT_RESET = 8'h00;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_WAIT = 6'b000100,
        ST_READ = 6'b001000,
        ST_WRITE = 6'b010000,
        ST_DONE = 6'b100000
    } phase_t;
endpackage

// ### word_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("word_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic push, pop;
    always_comb
    begin
        push = inValid && inReady;
        pop = outValid && outReady;
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
        outValid = wrPtr != rdPtr;
        outData = store[rdPtr[AW-1:0]];
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
    end
    always_ff @(posedge clk)
    begin
        if (push)
            store[wrPtr[AW-1:0]] <= inData;
    end
endmodule
`default_nettype wire

// ### spi_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module spi_port_monitor
    import spi_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spiSel_b,
    input wire logic clockPhase,
    input wire logic [23:0] applicationEvent,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn,
    input wire logic spiIrq_b,
    input wire logic memRead,
    input wire logic sideEffectStrobe,
    input wire logic [7:0] errorCount,
    input wire logic [3:0] errorCode,
    input wire logic accessGood
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Interrupt line must stay quiet while the event registers settle
    sequence irqHeld;
        spiIrq_b [*6];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    chk_oe_select: assert property ($fell(spiSel_b) |-> ##[2:4] serialDataOutEn)
        else $error("output enable late after select");
    chk_oe_release: assert property ($rose(spiSel_b) |-> ##[2:4] !serialDataOutEn)
        else $error("output enable held after deselect");
    chk_status_bit: assert property (($fell(spiSel_b) && clockPhase) |-> ##5 serialDataOut == accessGood)
        else $error("status bit does not match last access");
    chk_count_step: assert property ($changed(errorCount) |-> errorCount == $past(errorCount) + 8'h01)
        else $error("error counter did not step by one");
    chk_error_flag: assert property ($changed(errorCount) |-> ##[0:1] !accessGood)
        else $error("error counted on a good access");
    chk_error_code: assert property ($fell(accessGood) |-> ##[0:1] errorCode != ERR_NONE)
        else $error("error code empty after failed access");
    chk_side_good: assert property (sideEffectStrobe |-> spiSel_b ##[0:2] accessGood)
        else $error("side effect on a failed access");
    chk_read_spacing: assert property (memRead |=> !memRead [*8])
        else $error("read fetches too close together");
    chk_read_idle: assert property (spiSel_b [*6] |-> !memRead)
        else $error("fetch while deselected");
    chk_irq_delay: assert property ($rose(|applicationEvent) |=> irqHeld ##[1:4] !spiIrq_b)
        else $error("interrupt delay wrong");
endmodule
bind spi_slave_process_port spi_port_monitor u_monitor (.clk(clk), .rst_b(rst_b), .spiSel_b(spiSel_b),
    .clockPhase(clockPhase), .applicationEvent(applicationEvent), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .spiIrq_b(spiIrq_b), .memRead(memRead),
    .sideEffectStrobe(sideEffectStrobe), .errorCount(errorCount), .errorCode(errorCode),
    .accessGood(accessGood));
`default_nettype wire

// ### spi_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// Mode 3 master: clock idles high, data changes on falling edge
module spi_master_model
(
    input wire logic clk,
    input wire logic serialDataOut,
    output logic spiSel_b,
    output logic spiClk,
    output logic serialDataIn
);
    initial
    begin
        spiSel_b = 1'b1;
        spiClk = 1'b1;
        serialDataIn = 1'b1;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic select(output logic st);
        spiSel_b <= 1'b0;
        pause(8);
        st = serialDataOut;
    endtask

    // Sampling at the end of the high phase gives the slave a full half period
    task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nBits; i--)
        begin
            spiClk <= 1'b0;
            serialDataIn <= tx[i];
            pause(4);
            spiClk <= 1'b1;
            pause(4);
            rx[i] = serialDataOut;
        end
    endtask

    // Undriven line shows the inverse of its last value
    task automatic deselect();
        pause(4);
        spiSel_b <= 1'b1;
        serialDataIn <= ~serialDataIn;
        pause(8);
    endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import spi_port_pkg::*;
    localparam logic [23:0] EVENT = 24'h5AC3E1;
    localparam logic [2:0] RSV [4] = '{CMD_NOP, 3'h1, 3'h5, 3'h7};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic memWriteReady = 1'b1;
    logic [23:0] applicationEvent = 24'h000000;
    logic [7:0] readData = 8'h00;
    wire logic spiSel_b;
    wire logic spiClk;
    wire logic serialDataIn;
    logic serialDataOut, serialDataOutEn, spiIrq_b, memRead, memWrite;
    logic regWriteAllowed, sideEffectStrobe, accessGood;
    logic [15:0] memAddr;
    logic [7:0] memWriteData, errorCount;
    logic [3:0] errorCode;
    int failCount = 0;
    int numChecks = 0;
    int sideCount = 0;
    int rdCount = 0;
    logic [7:0] expCount = 8'h00;
    logic lastGood = 1'b1;
    logic [23:0] wrQ[$];

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // Fetch stretched to 200 ns so a hasty clock surely lands inside it
    spi_slave_process_port #(.FETCH_DELAY(10)) u_dut (.clk(clk), .rst_b(rst_b), .spiSel_b(spiSel_b),
        .spiClk(spiClk), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutEn(serialDataOutEn), .spiIrq_b(spiIrq_b), .clockPhase(1'b1), .clockPolarity(1'b1),
        .lateSample(1'b0), .busyOutEnable(1'b0), .applicationEvent(applicationEvent), .readData(readData),
        .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .memWriteData(memWriteData),
        .regWriteAllowed(regWriteAllowed), .sideEffectStrobe(sideEffectStrobe),
        .memWriteReady(memWriteReady), .errorCount(errorCount), .errorCode(errorCode),
        .accessGood(accessGood));
    spi_master_model u_master (.clk(clk), .serialDataOut(serialDataOut), .spiSel_b(spiSel_b),
        .spiClk(spiClk), .serialDataIn(serialDataIn));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction

    always @(posedge clk)
    begin
        readData <= pat(memAddr);
        if (memWrite === 1'b1)
            wrQ.push_back({memAddr, memWriteData});
        if (sideEffectStrobe === 1'b1)
            sideCount++;
        if (memRead === 1'b1)
            rdCount++;
    end

    task automatic checkVal(input logic [23:0] got, input logic [23:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic endOfTest();
        $display("checks=%0d failures=%0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic openAcc();
        logic st;
        u_master.select(st);
        checkVal(st, lastGood);
    endtask

    task automatic closeAcc(input logic good, input logic [3:0] code);
        int sc;
        sc = sideCount;
        u_master.deselect();
        checkVal(accessGood, good);
        if (!good)
        begin
            expCount++;
            checkVal(errorCode, code);
            checkVal(24'(sideCount), 24'(sc));
        end
        checkVal(errorCount, expCount);
        lastGood = good;
    endtask

    task automatic sendAddr(input logic [15:0] a, input logic [2:0] cmd, input int nExt);
        logic [7:0] r;
        u_master.xfer(a[12:5], 8, r);
        checkVal(r, EVENT[7:0]);
        u_master.xfer({a[4:0], (nExt > 0) ? CMD_EXTEND : cmd}, 8, r);
        checkVal(r, EVENT[15:8]);
        for (int i = 1; i <= nExt; i++)
        begin
            u_master.xfer({(i == nExt) ? a[15:13] : ~a[15:13], (i == nExt) ? cmd : CMD_EXTEND, 2'b00}, 8, r);
            if (i == 1)
                checkVal(r, EVENT[23:16]);
        end
    endtask

    task automatic writeBytes(input logic [15:0] a, input int n);
        logic [7:0] r;
        for (int i = 0; i < n; i++)
            u_master.xfer(~pat(a + 16'(i)), 8, r);
    endtask

    task automatic readBytes(input logic [15:0] a, input int n);
        logic [7:0] r;
        for (int i = 0; i < n; i++)
        begin
            u_master.xfer((i == n - 1) ? ALL_ONES : 8'h00, 8, r);
            checkVal(r, pat(a + 16'(i)));
        end
    endtask

    task automatic checkWr(input logic [15:0] a, input int n);
        int k;
        k = 0;
        while (wrQ.size() < n && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 400)
        begin
            failCount++;
            endOfTest();
        end
        for (int i = 0; i < n; i++)
            checkVal(wrQ.pop_front(), {a + 16'(i), ~pat(a + 16'(i))});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (60000) @(posedge clk);
        failCount++;
        endOfTest();
    end

    initial
    begin
        logic [7:0] r;
        int n;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        checkVal(spiIrq_b, 1'b1);
        applicationEvent <= EVENT;
        repeat (20) @(posedge clk);
        checkVal(spiIrq_b, 1'b0);
        openAcc();
        sendAddr(16'h0123, CMD_WRITE, 0);
        writeBytes(16'h0123, 3);
        closeAcc(1'b1, ERR_NONE);
        checkWr(16'h0123, 3);
        memWriteReady <= 1'b0;
        openAcc();
        sendAddr(16'hA456, CMD_WRITE, 2);
        writeBytes(16'hA456, 4);
        closeAcc(1'b1, ERR_NONE);
        checkVal(24'(wrQ.size()), 24'h000000);
        memWriteReady <= 1'b1;
        checkWr(16'hA456, 4);
        openAcc();
        sendAddr(16'h0040, CMD_READ_WAIT, 0);
        u_master.xfer(ALL_ONES, 8, r);
        readBytes(16'h0040, 3);
        closeAcc(1'b1, ERR_NONE);
        openAcc();
        sendAddr(16'hE001, CMD_READ, 1);
        u_master.pause(READ_TIME_NS / CLK_PERIOD_NS + 4);
        readBytes(16'hE001, 2);
        closeAcc(1'b1, ERR_NONE);
        n = rdCount;
        for (int c = 0; c < 4; c++)
        begin
            openAcc();
            sendAddr(16'h0200, RSV[c], 0);
            closeAcc(1'b1, ERR_NONE);
        end
        checkVal(24'(rdCount - n), 24'h000000);
        checkVal(24'(wrQ.size()), 24'h000000);
        openAcc();
        sendAddr(16'h0300, CMD_WRITE, 0);
        writeBytes(16'h0300, 1);
        u_master.xfer(8'h00, 3, r);
        closeAcc(1'b0, ERR_PARTIAL_BYTE);
        checkWr(16'h0300, 1);
        openAcc();
        sendAddr(16'h0050, CMD_READ_WAIT, 0);
        u_master.xfer(ALL_ONES, 8, r);
        u_master.xfer(8'h00, 8, r);
        closeAcc(1'b0, ERR_NO_TERMINATION);
        openAcc();
        sendAddr(16'h0050, CMD_READ_WAIT, 0);
        repeat (3) u_master.xfer(ALL_ONES, 8, r);
        closeAcc(1'b0, ERR_AFTER_TERMINATION);
        openAcc();
        sendAddr(16'h0050, CMD_READ, 0);
        u_master.xfer(ALL_ONES, 8, r);
        closeAcc(1'b0, ERR_CLOCK_WHILE_BUSY);
        openAcc();
        sendAddr(16'h0000, CMD_NOP, 0);
        closeAcc(1'b1, ERR_NONE);
        endOfTest();
    end
endmodule
`default_nettype wire
